// [hdl/tccu_pkg.sv]
// Functional notes
// (RULE1) one prescaled 16-bit counter, eight 16-bit channels
// (RULE2) direction bit: 0 capture, 1 compare
// (RULE3) enabled compare forces its pin direction
// (RULE4) port data writes latched while timer owns pin
// (RULE5) force bit does compare action, no flag
// (RULE6) force register always reads zero
// (RULE7) channel 7 mask makes compare pin output
// (RULE8) channel 7 match copies masked data bits
// (RULE9) channel 7 data wins same-cycle conflicts
// (RULE10) counter writable only in special mode
// (RULE11) software accesses counter as one word
// (RULE12) first period after counter write may vary
// (RULE13) enable bit clear stops timer and div64
// (RULE14) wait-stop bit halts timer in wait
// (RULE15) background-stop bit halts timer in debug
// (RULE16) fast clear: value access clears channel flag; the code clears it only on a capture-channel read or a compare-channel write
// (RULE17) fast clear: count access clears overflow flags
// (RULE18) action field: off, toggle, low, high
// (RULE19) nonzero action field makes pin an output
// (RULE20) edge field: off, rising, falling, both
// (RULE21) channel enables gate channel flags to interrupt
// (RULE22) overflow enable gates overflow flag to interrupt
// (RULE23) value register captures count or triggers compare
// (RULE24) writing one clears flag, zero keeps
// (RULE25) overflow flag set on wrap to zero
// (RULE26) counter reset enable: channel 7 match clears
// (RULE27) match at increment equal to value sets flag
// (RULE28) capture sets flag with latching cycle
package tccu_pkg;
  localparam logic [7:0]  IDX_FUNC      = 8'h80;
  localparam logic [7:0]  IDX_FORCE     = 8'h81;
  localparam logic [7:0]  IDX_C7_MASK   = 8'h82;
  localparam logic [7:0]  IDX_C7_DATA   = 8'h83;
  localparam logic [7:0]  IDX_COUNT     = 8'h84;
  localparam logic [7:0]  IDX_SYS_CTL   = 8'h86;
  localparam logic [7:0]  IDX_ACT_UP    = 8'h88;
  localparam logic [7:0]  IDX_ACT_LO    = 8'h89;
  localparam logic [7:0]  IDX_EDGE      = 8'h8a;
  localparam logic [7:0]  IDX_CH_IRQ    = 8'h8c;
  localparam logic [7:0]  IDX_OVF_CFG   = 8'h8d;
  localparam logic [7:0]  IDX_CH_FLAGS  = 8'h8e;
  localparam logic [7:0]  IDX_OVF_FLAGS = 8'h8f;
  localparam logic [3:0]  IDX_CHAN_HI   = 4'h9;
  localparam logic [7:0]  IDX_ACC_COUNT = 8'ha2;
  localparam logic [7:0]  IDX_PORT_DATA = 8'hae;
  localparam logic [7:0]  IDX_PORT_DIR  = 8'haf;
  localparam int          ENABLE_BIT    = 7;
  localparam int          WAIT_STOP_BIT = 6;
  localparam int          BKGD_STOP_BIT = 5;
  localparam int          FAST_CLR_BIT  = 4;
  localparam int          OVF_IRQ_BIT   = 7;
  localparam int          CNT_RST_BIT   = 3;
  localparam int          OVF_FLAG_BIT  = 7;
  localparam logic [7:0]  SYS_CTL_MASK  = 8'hf0;
  localparam logic [7:0]  OVF_CFG_MASK  = 8'h8f;
  localparam logic [2:0]  PRESCALE_MAX  = 3'h5;
  localparam logic [5:0]  PRESCALE_ONES = 6'h3f;
  localparam logic [5:0]  DIV64_POINT   = 6'h3f;
  localparam logic [15:0] COUNT_TOP     = 16'hffff;
  localparam logic [15:0] COUNT_ZERO    = 16'h0000;
  localparam logic [7:0]  REG8_RESET    = 8'h00;
  localparam logic [15:0] REG16_RESET   = 16'h0000;
  localparam logic [1:0]  ACT_TOGGLE    = 2'h1;
  localparam logic [1:0]  ACT_LOW       = 2'h2;
  localparam logic [1:0]  ACT_HIGH      = 2'h3;
  localparam logic [1:0]  HTRANS_IDLE   = 2'h0;
  localparam logic        HRESP_OKAY    = 1'b0;
endpackage

// [hdl/tccu_top.sv]
module tccu_top
(
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  input  wire logic        special_mode_in,
  input  wire logic        wait_mode_in,
  input  wire logic        background_mode_in,
  input  wire logic [7:0]  pin_in,
  output logic      [7:0]  pin_out,
  output logic      [7:0]  pin_oe_out,
  output logic             irq_out,
  output logic             div64_tick_out,
  output logic             acc_flag_clear_out
);
  import tccu_pkg::*;

  typedef struct packed {
    logic [7:0]       func_sel;
    logic [7:0]       c7_mask;
    logic [7:0]       c7_data;
    logic [7:0]       sys_ctl;
    logic [15:0]      action;
    logic [15:0]      edge_ctl;
    logic [7:0]       ch_irq;
    logic [7:0]       ovf_cfg;
    logic [15:0]      count;
    logic [5:0]       prescale;
    logic [7:0][15:0] value;
    logic [7:0]       flags;
    logic             ovf_flag;
    logic [7:0]       oc_level;
    logic [7:0]       port_data;
    logic [7:0]       port_dir;
    logic [7:0]       pin_prev;
    logic             wr_pend;
    logic [7:0]       wr_idx;
    logic [31:0]      hrdata;
    logic             hready;
    logic [7:0]       pin_out;
    logic [7:0]       pin_oe;
    logic             irq;
    logic             div64;
    logic             acc_clr;
  } tccu_state_type;

  tccu_state_type s;
  tccu_state_type next_s;

  always_comb
  begin
    logic        run;
    logic        tick;
    logic [2:0]  scale;
    logic [5:0]  pmask;
    logic [7:0]  match;
    logic [7:0]  force_ev;
    logic [7:0]  event_any;
    logic [7:0]  capture;
    logic [7:0]  rise;
    logic [7:0]  fall;
    logic [7:0]  flag_clr;
    logic [7:0]  flag_set;
    logic [7:0]  owned;
    logic        ovf_set;
    logic        ovf_clr;
    logic        fast;
    logic        accept;
    logic [7:0]  idx;
    logic [31:0] wd;
    logic [31:0] rd;
    logic [1:0]  act;
    logic [1:0]  edg;
    run       = 1'b0;
    tick      = 1'b0;
    scale     = 3'h0;
    pmask     = 6'h0;
    match     = 8'h0;
    force_ev  = 8'h0;
    event_any = 8'h0;
    capture   = 8'h0;
    rise      = 8'h0;
    fall      = 8'h0;
    flag_clr  = 8'h0;
    flag_set  = 8'h0;
    owned     = 8'h0;
    ovf_set   = 1'b0;
    ovf_clr   = 1'b0;
    fast      = 1'b0;
    accept    = 1'b0;
    idx       = 8'h0;
    wd        = hwdata_in;
    rd        = 32'h0;
    act       = 2'h0;
    edg       = 2'h0;
    next_s    = s;

    fast = s.sys_ctl[FAST_CLR_BIT];
    next_s.acc_clr = 1'b0;

    // timer runs unless disabled or halted by cpu mode
    run = s.sys_ctl[ENABLE_BIT]                                    // [RULE13]
        && !(s.sys_ctl[WAIT_STOP_BIT] && wait_mode_in)             // [RULE14]
        && !(s.sys_ctl[BKGD_STOP_BIT] && background_mode_in);      // [RULE15]

    // reserved prescale codes fall back to the largest factor
    scale = (s.ovf_cfg[2:0] > PRESCALE_MAX) ? PRESCALE_MAX : s.ovf_cfg[2:0];
    pmask = ~(PRESCALE_ONES << scale);
    if (run)
    begin
      next_s.prescale = s.prescale + 6'h1;
    end
    tick = run && ((s.prescale & pmask) == 6'h0);                  // [RULE1]
    next_s.div64 = run && (s.prescale == DIV64_POINT);             // [RULE13]

    if (s.wr_pend && (s.wr_idx == IDX_FORCE))
    begin
      force_ev = wd[7:0] & s.func_sel;                             // [RULE5]
    end

    for (int i = 0; i < 8; i++)
    begin
      match[i] = tick && s.func_sel[i] && (s.count == s.value[i]); // [RULE27]
    end
    event_any = match | force_ev;

    if (tick)
    begin
      if (s.ovf_cfg[CNT_RST_BIT] && match[7])
      begin
        next_s.count = COUNT_ZERO;                                 // [RULE26]
      end
      else
      begin
        next_s.count = s.count + 16'h1;
        ovf_set = (s.count == COUNT_TOP);                          // [RULE25]
      end
    end

    // compare actions, channel 7 data applied last so it wins
    for (int i = 0; i < 8; i++)
    begin
      act = s.action[2*i +: 2];
      if (event_any[i])
      begin
        unique case (act)                                          // [RULE18]
          ACT_TOGGLE: next_s.oc_level[i] = ~s.oc_level[i];
          ACT_LOW:    next_s.oc_level[i] = 1'b0;
          ACT_HIGH:   next_s.oc_level[i] = 1'b1;
          default:    ;
        endcase
      end
    end
    if (event_any[7])
    begin
      for (int i = 0; i < 8; i++)
      begin
        if (s.c7_mask[i])
        begin
          next_s.oc_level[i] = s.c7_data[i];                       // [RULE8] [RULE9]
        end
      end
    end

    // edge detection on capture channels
    rise = pin_in & ~s.pin_prev;
    fall = ~pin_in & s.pin_prev;
    next_s.pin_prev = pin_in;
    for (int i = 0; i < 8; i++)
    begin
      edg = s.edge_ctl[2*i +: 2];
      capture[i] = run && !s.func_sel[i]                           // [RULE2]
                && ((edg[0] && rise[i]) || (edg[1] && fall[i]));   // [RULE20]
      if (capture[i])
      begin
        next_s.value[i] = s.count;                                 // [RULE23]
      end
    end
    flag_set = match | capture;                                    // [RULE28]

    // data phase of a write
    if (s.wr_pend)
    begin
      if ((s.wr_idx[7:4] == IDX_CHAN_HI) && !s.wr_idx[0])
      begin
        if (s.func_sel[s.wr_idx[3:1]])
        begin
          next_s.value[s.wr_idx[3:1]] = wd[15:0];
          if (fast)
          begin
            flag_clr[s.wr_idx[3:1]] = 1'b1;                        // [RULE16]
          end
        end
      end
      unique case (s.wr_idx)
        IDX_FUNC:      next_s.func_sel = wd[7:0];
        IDX_C7_MASK:   next_s.c7_mask = wd[7:0];
        IDX_C7_DATA:   next_s.c7_data = wd[7:0];
        IDX_SYS_CTL:   next_s.sys_ctl = wd[7:0] & SYS_CTL_MASK;
        IDX_ACT_UP:    next_s.action[15:8] = wd[7:0];
        IDX_ACT_LO:    next_s.action[7:0] = wd[7:0];
        IDX_EDGE:      next_s.edge_ctl = wd[15:0];
        IDX_CH_IRQ:    next_s.ch_irq = wd[7:0];
        IDX_OVF_CFG:   next_s.ovf_cfg = wd[7:0] & OVF_CFG_MASK;
        IDX_CH_FLAGS:  flag_clr = flag_clr | wd[7:0];              // [RULE24]
        IDX_OVF_FLAGS: ovf_clr = wd[OVF_FLAG_BIT];                 // [RULE24]
        IDX_PORT_DATA: next_s.port_data = wd[7:0];                 // [RULE4]
        IDX_PORT_DIR:  next_s.port_dir = wd[7:0];
        IDX_COUNT:
        begin
          // prescaler left alone, so the first period may be short
          if (special_mode_in)
          begin
            next_s.count = wd[15:0];                               // [RULE10] [RULE12]
          end
        end
        default:       ;
      endcase
    end

    // address phase: zero wait states, read data registered here
    accept = hsel_in && htrans_in[1] && hready_in;
    idx = haddr_in[9:2];
    next_s.wr_pend = 1'b0;
    if (accept && (haddr_in[31:10] == 22'h0))
    begin
      next_s.wr_pend = hwrite_in;
      next_s.wr_idx = idx;
      if (fast && (idx == IDX_COUNT))
      begin
        ovf_clr = 1'b1;                                            // [RULE17]
      end
      if (fast && (idx == IDX_ACC_COUNT))
      begin
        next_s.acc_clr = 1'b1;                                     // [RULE17]
      end
      if (!hwrite_in)
      begin
        if ((idx[7:4] == IDX_CHAN_HI) && !idx[0])
        begin
          rd = {16'h0, s.value[idx[3:1]]};
          if (fast && !s.func_sel[idx[3:1]])
          begin
            flag_clr[idx[3:1]] = 1'b1;                             // [RULE16]
          end
        end
        unique case (idx)
          IDX_FUNC:      rd = {24'h0, s.func_sel};
          IDX_FORCE:     rd = 32'h0;                               // [RULE6]
          IDX_C7_MASK:   rd = {24'h0, s.c7_mask};
          IDX_C7_DATA:   rd = {24'h0, s.c7_data};
          IDX_COUNT:     rd = {16'h0, s.count};                    // [RULE11]
          IDX_SYS_CTL:   rd = {24'h0, s.sys_ctl};
          IDX_ACT_UP:    rd = {24'h0, s.action[15:8]};
          IDX_ACT_LO:    rd = {24'h0, s.action[7:0]};
          IDX_EDGE:      rd = {16'h0, s.edge_ctl};
          IDX_CH_IRQ:    rd = {24'h0, s.ch_irq};
          IDX_OVF_CFG:   rd = {24'h0, s.ovf_cfg};
          IDX_CH_FLAGS:  rd = {24'h0, s.flags};
          IDX_OVF_FLAGS: rd = {24'h0, s.ovf_flag, 7'h0};
          IDX_PORT_DATA: rd = {24'h0, (s.port_data & s.pin_oe) | (pin_in & ~s.pin_oe)};
          IDX_PORT_DIR:  rd = {24'h0, s.port_dir};
          default:       ;
        endcase
        next_s.hrdata = rd;
      end
    end

    // a hardware set in the clearing cycle survives
    next_s.flags = (s.flags & ~flag_clr) | flag_set;               // [RULE24]
    next_s.ovf_flag = (s.ovf_flag && !ovf_clr) || ovf_set;         // [RULE25]

    // pin ownership follows the newly registered configuration
    for (int i = 0; i < 8; i++)
    begin
      owned[i] = next_s.func_sel[i]
              && ((next_s.action[2*i +: 2] != 2'h0)                // [RULE3] [RULE19]
              || next_s.c7_mask[i]);                               // [RULE7]
    end
    next_s.pin_oe = owned | next_s.port_dir;
    next_s.pin_out = (owned & next_s.oc_level)
                   | (~owned & next_s.port_data);                  // [RULE4]
    next_s.irq = (|(next_s.flags & next_s.ch_irq))                 // [RULE21]
              || (next_s.ovf_flag && next_s.ovf_cfg[OVF_IRQ_BIT]); // [RULE22]
    next_s.hready = 1'b1;
  end

  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      s.func_sel  <= REG8_RESET;
      s.c7_mask   <= REG8_RESET;
      s.c7_data   <= REG8_RESET;
      s.sys_ctl   <= REG8_RESET;
      s.action    <= REG16_RESET;
      s.edge_ctl  <= REG16_RESET;
      s.ch_irq    <= REG8_RESET;
      s.ovf_cfg   <= REG8_RESET;
      s.count     <= REG16_RESET;
      s.prescale  <= 6'h0;
      s.value     <= '0;
      s.flags     <= REG8_RESET;
      s.ovf_flag  <= 1'b0;
      s.oc_level  <= REG8_RESET;
      s.port_data <= REG8_RESET;
      s.port_dir  <= REG8_RESET;
      s.pin_prev  <= REG8_RESET;
      s.wr_pend   <= 1'b0;
      s.wr_idx    <= REG8_RESET;
      s.hrdata    <= 32'h0;
      s.hready    <= 1'b1;
      s.pin_out   <= REG8_RESET;
      s.pin_oe    <= REG8_RESET;
      s.irq       <= 1'b0;
      s.div64     <= 1'b0;
      s.acc_clr   <= 1'b0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign hrdata_out         = s.hrdata;
  assign hreadyout_out      = s.hready;
  assign hresp_out          = HRESP_OKAY;
  assign pin_out            = s.pin_out;
  assign pin_oe_out         = s.pin_oe;
  assign irq_out            = s.irq;
  assign div64_tick_out     = s.div64;
  assign acc_flag_clear_out = s.acc_clr;
endmodule

// [verif/tccu_top_monitor.sv]
module tccu_top_monitor
  import tccu_pkg::*;
(
  input wire logic        clk_in,
  input wire logic        resetn_in,
  input wire logic        hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0]  htrans_in,
  input wire logic        hwrite_in,
  input wire logic [31:0] hwdata_in,
  input wire logic        hready_in,
  input wire logic [31:0] hrdata_out,
  input wire logic        hreadyout_out,
  input wire logic        wait_mode_in,
  input wire logic        background_mode_in,
  input wire logic        irq_out,
  input wire logic        div64_tick_out,
  input wire logic        acc_flag_clear_out
);
  logic       dp_w;
  logic       overflow_irq_enable;
  logic       tk;
  logic       run;
  logic [7:0] dp_i, ctl, chm;
  assign tk = hsel_in && htrans_in[1] && hready_in;
  assign run = ctl[7] && !(ctl[6] && wait_mode_in) && !(ctl[5] && background_mode_in);
  // shadow of the control bits the properties depend on
  always_ff @(posedge clk_in)
  begin
    dp_w <= resetn_in && tk && hwrite_in;
    dp_i <= haddr_in[9:2];
    if (!resetn_in)
      {ctl, chm, overflow_irq_enable} <= 17'h0;
    else if (dp_w && dp_i == IDX_SYS_CTL)
      ctl <= hwdata_in[7:0];
    else if (dp_w && dp_i == IDX_CH_IRQ)
      chm <= hwdata_in[7:0];
    else if (dp_w && dp_i == IDX_OVF_CFG)
      overflow_irq_enable <= hwdata_in[OVF_IRQ_BIT];
  end
  default clocking mc @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  sequence rd_at(logic [7:0] i);
    tk && !hwrite_in && haddr_in == {22'h0, i, 2'h0};
  endsequence
  AST_READY: assert property (hreadyout_out)
    else $error("wait state inserted");
  AST_FORCE_ZERO: assert property (rd_at(IDX_FORCE) |=> hrdata_out == 32'h0)
    else $error("force register read not zero");
  AST_UNMAPPED: assert property (rd_at(8'hff) |=> hrdata_out == 32'h0)
    else $error("unmapped read not zero");
  AST_DIV64_STOP: assert property (!run && !$past(run) |-> !div64_tick_out)
    else $error("divide tick while timer stopped");
  AST_DIV64_GAP: assert property (div64_tick_out |=> !div64_tick_out [*8])
    else $error("divide ticks too close");
  AST_IRQ_MASK: assert property (chm == 8'h00 && !overflow_irq_enable |-> !irq_out)
    else $error("interrupt with all enables clear");
  AST_ACC_PULSE: assert property (rd_at(IDX_ACC_COUNT) ##0 ctl[FAST_CLR_BIT] |-> ##[0:2] acc_flag_clear_out)
    else $error("accumulator flag clear missing");
  AST_ACC_GATE: assert property (acc_flag_clear_out |-> ctl[FAST_CLR_BIT] || $past(ctl[FAST_CLR_BIT]))
    else $error("accumulator clear without fast clear");
endmodule

// [verif/tccu_pins.sv]
module tccu_pins
(
  input  wire logic       clk_in,
  input  wire logic [7:0] drive_in,
  input  wire logic [7:0] oe_in,
  input  wire logic [7:0] ext_in,
  input  wire logic [7:0] ext_en_in,
  output logic      [7:0] level_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] noise = 8'h55;
  // undriven lines wander so a stale level never looks valid
  always @(posedge clk_in)
    noise <= ~noise;
  always_comb
    for (int i = 0; i < 8; i++)
      if (oe_in[i])
        level_out[i] = drive_in[i];
      else
        level_out[i] = ext_en_in[i] ? ext_in[i] : noise[i];
endmodule

// [verif/timer_capture_compare_unit_test.sv]
module timer_capture_compare_unit_test;
  timeunit 1ns;
  timeprecision 1ns;
  import tccu_pkg::*;
  logic        clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwr = 1'b0;
  logic        spec = 1'b0, wm = 1'b0, bm = 1'b0, rdy, irq;
  logic [1:0]  htr = HTRANS_IDLE;
  logic [31:0] ha = 32'h0, hwd = 32'h0, hrd, r, c0;
  logic [7:0]  ext = 8'h00, pin, po, poe;
  int          n_fail = 0, checked = 0, cyc = 0;
  logic [7:0]  ia [11] = '{IDX_FUNC, IDX_ACT_UP, IDX_ACT_LO, IDX_C7_MASK, IDX_C7_DATA,
                           8'h90, 8'h92, 8'h98, 8'h9a, 8'h9e, IDX_EDGE};
  logic [15:0] da [11] = '{16'hb3, 16'h08, 16'h01, 16'h30, 16'h30, 16'h40, 16'hff00,
                           16'hff00, 16'h80, 16'h80, 16'h10};
  logic [7:0]  sc [4] = '{8'h00, 8'hc0, 8'ha0, 8'h80};
  tccu_top tccu_top_i (.clk_in(clk), .resetn_in(rstn), .hsel_in(hsel), .haddr_in(ha),
    .htrans_in(htr), .hwrite_in(hwr), .hsize_in(3'h2), .hwdata_in(hwd), .hready_in(rdy),
    .hrdata_out(hrd), .hreadyout_out(rdy), .hresp_out(), .special_mode_in(spec),
    .wait_mode_in(wm), .background_mode_in(bm), .pin_in(pin), .pin_out(po),
    .pin_oe_out(poe), .irq_out(irq), .div64_tick_out(), .acc_flag_clear_out());
  tccu_pins tccu_pins_i (.clk_in(clk), .drive_in(po), .oe_in(poe), .ext_in(ext),
    .ext_en_in(8'h04), .level_out(pin));
  task automatic finish_test();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      n_fail++;
      $display("ERROR %0t saw %h want %h", $time, s, e);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] i, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htr <= 2'h2;
    hwr <= w;
    ha <= {22'h0, i, 2'h0};
    do @(posedge clk); while (rdy !== 1'b1);
    hsel <= 1'b0;
    htr <= HTRANS_IDLE;
    hwd <= d;
    do @(posedge clk); while (rdy !== 1'b1);
    r = hrd;
  endtask
  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    bus(1'b1, i, d);
  endtask
  task automatic rc(input logic [7:0] i, input logic [31:0] e);
    bus(1'b0, i, 32'h0);
    check(r, e);
  endtask
  task automatic poll(input logic [7:0] i, input logic [31:0] m);
    do bus(1'b0, i, 32'h0); while ((r & m) !== m);
  endtask
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask
  initial
    forever #25 clk = ~clk;
  always @(posedge clk)
    if (++cyc > 20000)
    begin
      n_fail++;
      finish_test();
    end
  initial
  begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    rc(IDX_FORCE, 32'h0);
    rc(8'hff, 32'h0);
    rc(IDX_ACT_UP, 32'h0);
    wr(IDX_COUNT, 32'h1234);
    rc(IDX_COUNT, 32'h0);
    spec <= 1'b1;
    wr(IDX_COUNT, 32'h1234);
    rc(IDX_COUNT, 32'h1234);
    wr(IDX_COUNT, 32'h0);
    spec <= 1'b0;
    for (int k = 0; k < 11; k++)
      wr(ia[k], da[k]);
    settle();
    check(poe, 8'h31);
    wr(IDX_SYS_CTL, 32'h80);
    poll(IDX_CH_FLAGS, 32'ha1);
    check(r, 32'ha1);
    settle();
    check(po & 8'h31, 8'h31);
    wr(IDX_CH_FLAGS, 32'h0);
    rc(IDX_CH_FLAGS, 32'ha1);
    wr(IDX_CH_FLAGS, 32'h1);
    rc(IDX_CH_FLAGS, 32'ha0);
    for (int k = 3; k >= 0; k--)
    begin
      wr(IDX_ACT_LO, {k[1:0], 2'h1});
      wr(IDX_FORCE, 32'h2);
      settle();
      check(poe[1], k != 0);
      if (k != 0)
        check(po[1], k != 2);
    end
    rc(IDX_CH_FLAGS, 32'ha0);
    rc(IDX_FORCE, 32'h0);
    bus(1'b0, IDX_COUNT, 32'h0);
    c0 = r;
    ext <= 8'h04;
    poll(IDX_CH_FLAGS, 32'h04);
    bus(1'b0, 8'h94, 32'h0);
    check(r - c0 < 32'h20, 1'b1);
    wr(IDX_CH_FLAGS, 32'h04);
    ext <= 8'h00;
    settle();
    rc(IDX_CH_FLAGS, 32'ha0);
    wr(IDX_CH_IRQ, 32'h80);
    settle();
    check(irq, 1'b1);
    wr(IDX_CH_IRQ, 32'h01);
    settle();
    check(irq, 1'b0);
    wr(IDX_CH_IRQ, 32'h0);
    wr(IDX_CH_FLAGS, 32'hff);
    wr(IDX_SYS_CTL, 32'h90);
    wr(IDX_OVF_CFG, 32'h80);
    spec <= 1'b1;
    wr(IDX_COUNT, 32'hfff0);
    spec <= 1'b0;
    poll(IDX_OVF_FLAGS, 32'h80);
    settle();
    check(irq, 1'b1);
    bus(1'b0, IDX_COUNT, 32'h0);
    rc(IDX_OVF_FLAGS, 32'h0);
    poll(IDX_CH_FLAGS, 32'h80);
    wr(8'h9e, 32'h80);
    rc(IDX_CH_FLAGS, 32'h21);
    bus(1'b0, IDX_ACC_COUNT, 32'h0);
    // stopped, wait-stopped, debug-stopped, then running through both modes
    for (int k = 0; k < 4; k++)
    begin
      wm <= (k == 1 || k == 3);
      bm <= (k == 2 || k == 3);
      wr(IDX_SYS_CTL, sc[k]);
      bus(1'b0, IDX_COUNT, 32'h0);
      c0 = r;
      bus(1'b0, IDX_COUNT, 32'h0);
      check(r === c0, k < 3);
    end
    // channel 7 match at 0x80 must pull the counter back to zero
    spec <= 1'b1;
    wr(IDX_COUNT, 32'h0);
    spec <= 1'b0;
    wr(IDX_OVF_CFG, 32'h08);
    repeat (300) @(posedge clk);
    bus(1'b0, IDX_COUNT, 32'h0);
    check(r <= 32'h80, 1'b1);
    finish_test();
  end
endmodule
bind tccu_top tccu_top_monitor tccu_top_monitor_i (.clk_in(clk_in), .resetn_in(resetn_in),
  .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
  .hwdata_in(hwdata_in), .hready_in(hready_in), .hrdata_out(hrdata_out),
  .hreadyout_out(hreadyout_out), .wait_mode_in(wait_mode_in),
  .background_mode_in(background_mode_in), .irq_out(irq_out),
  .div64_tick_out(div64_tick_out), .acc_flag_clear_out(acc_flag_clear_out));
